// file: design/sdram_cke_pkg.sv
// constants shared by the command capture and power state logic
// assumes a controller that drives defined levels on every bus bit
package sdram_cke_pkg;

   localparam int CA_W = 10;
   localparam int BANK_W = 3;
   localparam int NUM_BANKS = 8;
   localparam int COL_W = 12;
   localparam int BURST_W = 8;
   // field positions on the command/address bus
   localparam int BANK_LSB = 7;
   localparam int BANK_MSB = 9;
   localparam int ALL_BANK_BIT = 4;
   localparam int AUTO_PRE_BIT = 0;
   localparam int COL_RISE_LSB = 5;
   localparam int COL_RISE_MSB = 6;
   localparam int COL_FALL_LSB = 1;
   localparam int COL_FALL_MSB = 9;
   // reset values
   localparam logic [NUM_BANKS-1:0] BANKS_RST = 8'h00;
   localparam logic [BURST_W-1:0] BURST_RST = 8'h00;

   typedef enum logic [3:0] {
      CMD_NOP = 4'h0,
      CMD_MRW = 4'h1,
      CMD_MRR = 4'h2,
      CMD_REF_BANK = 4'h3,
      CMD_REF_ALL = 4'h4,
      CMD_ACTIVATE = 4'h5,
      CMD_WRITE = 4'h6,
      CMD_READ = 4'h7,
      CMD_PRECHARGE = 4'h8,
      CMD_BURST_STOP = 4'h9,
      CMD_AUTONOMOUS_REFRESH_STATE_ENTER = 4'ha,
      CMD_DEEP_ENTER = 4'hb,
      CMD_LP_ENTER = 4'hc,
      CMD_LP_EXIT = 4'hd,
      CMD_MAINTAIN = 4'he,
      CMD_ILLEGAL = 4'hf
   } cmd_t;

   typedef enum logic [3:0] {
      ST_POWER_ON = 4'h0,
      ST_RESETTING = 4'h1,
      ST_IDLE = 4'h2,
      ST_ACTIVE = 4'h3,
      ST_ACTIVE_LP = 4'h4,
      ST_IDLE_LP = 4'h5,
      ST_RESET_LP = 4'h6,
      ST_AUTO_REFRESH = 4'h7,
      ST_DEEP_SLEEP = 4'h8
   } state_t;

endpackage

// file: design/sdram_cke_power_state_decoder.sv
// command capture, bank tracking and clock-enable power states
// assumes i_link_clk is the memory clock, free of glitches; status
// leaves on i_clock through a req/ack handshake
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module sdram_cke_power_state_decoder
   import sdram_cke_pkg::*;
#(
   parameter int unsigned BURST_CYCLES = 4
)
(
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_link_clk,
   input wire logic i_cs_n,
   input wire logic i_cke,
   input wire logic [CA_W-1:0] i_cmd_addr_bus,
   input wire logic i_final_init_wait_done,
   output logic [3:0] o_power_state,
   output logic [NUM_BANKS-1:0] o_banks_open,
   output logic o_burst_active,
   output logic o_cmd_valid,
   output logic [3:0] o_cmd_code,
   output logic [BANK_W-1:0] o_cmd_bank,
   output logic [COL_W-1:0] o_cmd_col,
   output logic o_cmd_auto_precharge_flag,
   output logic o_cmd_all_bank_flag
);

   localparam int SNAP_W = 4 + NUM_BANKS + 1 + 1 + 4 + BANK_W + COL_W + 2;

   function automatic cmd_t decode(input logic prev, input logic cur,
      input logic cs_n, input logic [3:0] ca);
      cmd_t c;
      c = CMD_ILLEGAL;
      if (prev && cur)
      begin
         if (cs_n) c = CMD_NOP;
         else
         begin
            // ca3/ca4 of read and write are reserved: unused
            casez ({ca[0], ca[1], ca[2], ca[3]})
               4'b0000: c = CMD_MRW;
               4'b0001: c = CMD_MRR;
               4'b0010: c = CMD_REF_BANK;
               4'b0011: c = CMD_REF_ALL;
               4'b01??: c = CMD_ACTIVATE;
               4'b100?: c = CMD_WRITE;
               4'b101?: c = CMD_READ;
               4'b1101: c = CMD_PRECHARGE;
               4'b1100: c = CMD_BURST_STOP;
               default: c = CMD_NOP;
            endcase
         end
      end
      else if (prev && !cur)
      begin
         if (cs_n) c = CMD_LP_ENTER;
         else if (ca[2:0] == 3'b100) c = CMD_AUTONOMOUS_REFRESH_STATE_ENTER;
         else if (ca[2:0] == 3'b011) c = CMD_DEEP_ENTER;
      end
      else if (!prev && cur)
      begin
         if (cs_n) c = CMD_LP_EXIT;
      end
      else
         c = CMD_MAINTAIN;
      return c;
   endfunction

   // ---------------------------------------------------------------
   // link domain reset and input capture
   // ---------------------------------------------------------------
   // reset asserts at once, releases on the link clock
   logic link_rst_meta_r;
   logic link_rst_r;
   always_ff @(posedge i_link_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         link_rst_meta_r <= 1'b1;
         link_rst_r <= 1'b1;
      end
      else
      begin
         link_rst_meta_r <= 1'b0;
         link_rst_r <= link_rst_meta_r;
      end
   end

   // falling-edge half of the command; read one rising edge later
   logic [CA_W-1:0] ca_fall_r;
   always_ff @(negedge i_link_clk or posedge link_rst_r)
   begin
      if (link_rst_r) ca_fall_r <= '0;
      else ca_fall_r <= i_cmd_addr_bus;
   end

   // ---------------------------------------------------------------
   // link domain command and power state logic
   // ---------------------------------------------------------------
   logic cs_n_r, cs_n_nxt;
   logic cke_r, cke_nxt;
   logic cke_prev_r, cke_prev_nxt;
   logic [CA_W-1:0] ca_rise_r, ca_rise_nxt;
   logic init_meta_r, init_done_r;
   state_t state_r, state_nxt;
   logic [NUM_BANKS-1:0] banks_r, banks_nxt;
   logic [BURST_W-1:0] burst_r, burst_nxt;
   logic ap_pend_r, ap_pend_nxt;
   logic [BANK_W-1:0] ap_bank_r, ap_bank_nxt;
   logic cmd_pend_r, cmd_pend_nxt;
   logic [SNAP_W-1:0] info_r, info_nxt;
   logic [SNAP_W-1:0] snap_r, snap_nxt;
   logic req_r, req_nxt;
   logic ack_meta_r, ack_sync_r;
   logic ack_r;
   cmd_t cmd;
   logic [BANK_W-1:0] bank;
   logic [COL_W-1:0] col;
   logic load;

   always_comb
   begin
      // chip select and clock enable only at rising edges
      cs_n_nxt = i_cs_n;
      cke_nxt = i_cke;
      cke_prev_nxt = cke_r;
      ca_rise_nxt = i_cmd_addr_bus;
      cmd = decode(cke_prev_r, cke_r, cs_n_r, ca_rise_r[3:0]);
      bank = ca_rise_r[BANK_MSB:BANK_LSB];
      col = {ca_fall_r[COL_FALL_MSB:COL_FALL_LSB],
         ca_rise_r[COL_RISE_MSB:COL_RISE_LSB], 1'b0};
      state_nxt = state_r;
      banks_nxt = banks_r;
      ap_pend_nxt = ap_pend_r;
      ap_bank_nxt = ap_bank_r;
      burst_nxt = burst_r;
      // a running burst counts down unless a read or write reloads it or a burst stop clears it
      if (burst_r != BURST_RST)
      begin
         burst_nxt = burst_r - 8'h01;
         if (burst_r == 8'h01 && ap_pend_r)
         begin
            banks_nxt[ap_bank_r] = 1'b0;
            ap_pend_nxt = 1'b0;
         end
      end
      unique case (state_r)
         ST_POWER_ON:
            // reset is carried by a mode register write
            if (cmd == CMD_MRW) state_nxt = ST_RESETTING;
         ST_RESETTING:
            if (cmd == CMD_LP_ENTER) state_nxt = ST_RESET_LP;
            else if (init_done_r) state_nxt = ST_IDLE;
         ST_IDLE, ST_ACTIVE:
         begin
            // ordinary decoding, and low-power entry as clock enable falls
            unique case (cmd)
               CMD_ACTIVATE: banks_nxt[bank] = 1'b1;
               CMD_PRECHARGE:
                  if (ca_rise_r[ALL_BANK_BIT]) banks_nxt = '0;
                  else banks_nxt[bank] = 1'b0;
               CMD_READ, CMD_WRITE:
               begin
                  burst_nxt = 8'(BURST_CYCLES);
                  ap_pend_nxt = ca_fall_r[AUTO_PRE_BIT];
                  ap_bank_nxt = bank;
               end
               CMD_BURST_STOP:
               begin
                  burst_nxt = BURST_RST;
                  if (ap_pend_r) banks_nxt[ap_bank_r] = 1'b0;
                  ap_pend_nxt = 1'b0;
               end
               CMD_LP_ENTER:
                  state_nxt = (banks_r != BANKS_RST) ? ST_ACTIVE_LP
                     : ST_IDLE_LP;
               CMD_AUTONOMOUS_REFRESH_STATE_ENTER:
                  if (state_r == ST_IDLE && banks_r == BANKS_RST)
                     state_nxt = ST_AUTO_REFRESH;
               CMD_DEEP_ENTER:
                  if (state_r == ST_IDLE && banks_r == BANKS_RST)
                     state_nxt = ST_DEEP_SLEEP;
               default: ; // illegal or idle codes change nothing
            endcase
            if (state_nxt == ST_IDLE || state_nxt == ST_ACTIVE)
               state_nxt = (banks_nxt != BANKS_RST) ? ST_ACTIVE : ST_IDLE;
         end
         ST_ACTIVE_LP:
            if (cmd == CMD_LP_EXIT) state_nxt = ST_ACTIVE;
         ST_IDLE_LP:
            if (cmd == CMD_LP_EXIT) state_nxt = ST_IDLE;
         ST_RESET_LP:
            if (cmd == CMD_LP_EXIT)
               state_nxt = init_done_r ? ST_IDLE : ST_RESETTING;
         // exit needs only clock enable high: the clock may have
         // stopped, so no registered low edge is demanded
         ST_AUTO_REFRESH:
            if (cke_r) state_nxt = ST_IDLE;
         ST_DEEP_SLEEP:
            if (cke_r)
            begin
               state_nxt = ST_POWER_ON;
               banks_nxt = '0;
            end
         default: state_nxt = ST_POWER_ON;
      endcase
      // snapshot for the system clock; newest command wins
      info_nxt = info_r;
      cmd_pend_nxt = cmd_pend_r;
      load = (req_r == ack_sync_r);
      if (load) cmd_pend_nxt = 1'b0;
      if (cmd != CMD_NOP && cmd != CMD_MAINTAIN && cmd != CMD_ILLEGAL)
      begin
         cmd_pend_nxt = 1'b1; // set wins over the clear
         info_nxt = {4'h0, BANKS_RST, 1'b0, 1'b0, cmd, bank, col,
            ca_fall_r[AUTO_PRE_BIT], ca_rise_r[ALL_BANK_BIT]};
      end
      snap_nxt = snap_r;
      req_nxt = req_r;
      if (load && (cmd_pend_r || snap_r[SNAP_W-1 -: 4] != state_r
         || snap_r[SNAP_W-5 -: NUM_BANKS] != banks_r
         || snap_r[SNAP_W-5-NUM_BANKS] != (burst_r != BURST_RST)))
      begin
         snap_nxt = {state_r, banks_r, burst_r != BURST_RST, cmd_pend_r,
            info_r[SNAP_W-15:0]};
         req_nxt = ~req_r;
      end
   end

   always_ff @(posedge i_link_clk or posedge link_rst_r)
   begin
      if (link_rst_r)
      begin
         cs_n_r <= 1'b1;
         cke_r <= 1'b0;
         cke_prev_r <= 1'b0;
         ca_rise_r <= '0;
         init_meta_r <= 1'b0;
         init_done_r <= 1'b0;
         state_r <= ST_POWER_ON;
         banks_r <= BANKS_RST;
         burst_r <= BURST_RST;
         ap_pend_r <= 1'b0;
         ap_bank_r <= '0;
         cmd_pend_r <= 1'b0;
         info_r <= '0;
         snap_r <= '0;
         req_r <= 1'b0;
         ack_meta_r <= 1'b0;
         ack_sync_r <= 1'b0;
      end
      else
      begin
         cs_n_r <= cs_n_nxt;
         cke_r <= cke_nxt;
         cke_prev_r <= cke_prev_nxt;
         ca_rise_r <= ca_rise_nxt;
         init_meta_r <= i_final_init_wait_done;
         init_done_r <= init_meta_r;
         state_r <= state_nxt;
         banks_r <= banks_nxt;
         burst_r <= burst_nxt;
         ap_pend_r <= ap_pend_nxt;
         ap_bank_r <= ap_bank_nxt;
         cmd_pend_r <= cmd_pend_nxt;
         info_r <= info_nxt;
         snap_r <= snap_nxt;
         req_r <= req_nxt;
         ack_meta_r <= ack_r;
         ack_sync_r <= ack_meta_r;
      end
   end

   // ---------------------------------------------------------------
   // system clock side of the handshake
   // ---------------------------------------------------------------
   // limitation: commands closer than one handshake collapse to the last
   logic req_meta_r, req_sync_r;
   logic ack_nxt;
   logic take;
   logic [SNAP_W-1:0] out_r, out_nxt;
   logic valid_r, valid_nxt;

   always_comb
   begin
      take = (req_sync_r != ack_r);
      ack_nxt = take ? req_sync_r : ack_r;
      out_nxt = take ? snap_r : out_r;
      valid_nxt = take && snap_r[SNAP_W-6-NUM_BANKS];
   end

   always_ff @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
      begin
         req_meta_r <= 1'b0;
         req_sync_r <= 1'b0;
         ack_r <= 1'b0;
         out_r <= '0;
         valid_r <= 1'b0;
      end
      else
      begin
         req_meta_r <= req_r;
         req_sync_r <= req_meta_r;
         ack_r <= ack_nxt;
         out_r <= out_nxt;
         valid_r <= valid_nxt;
      end
   end

   assign o_power_state = out_r[SNAP_W-1 -: 4];
   assign o_banks_open = out_r[SNAP_W-5 -: NUM_BANKS];
   assign o_burst_active = out_r[SNAP_W-5-NUM_BANKS];
   assign o_cmd_valid = valid_r;
   assign o_cmd_code = out_r[SNAP_W-15 -: 4];
   assign o_cmd_bank = out_r[COL_W+2 +: BANK_W];
   assign o_cmd_col = out_r[2 +: COL_W];
   assign o_cmd_auto_precharge_flag = out_r[1];
   assign o_cmd_all_bank_flag = out_r[0];

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   function automatic logic low_power(input state_t s);
      return s inside {ST_ACTIVE_LP, ST_IDLE_LP, ST_RESET_LP,
         ST_AUTO_REFRESH, ST_DEEP_SLEEP};
   endfunction

   a_lp_maintain: assert property (
      @(posedge i_link_clk) disable iff (link_rst_r)
      low_power(state_r) && !cke_prev_r && !cke_r
      |=> state_r == $past(state_r))
      else $error("low-power state left with clock enable low");
   a_lp_exit_act: assert property (
      @(posedge i_link_clk) disable iff (link_rst_r)
      state_r == ST_ACTIVE_LP && !cke_prev_r && cke_r && cs_n_r
      |=> state_r == ST_ACTIVE)
      else $error("active power-down exit missed");
   a_deep_exit: assert property (
      @(posedge i_link_clk) disable iff (link_rst_r)
      state_r == ST_DEEP_SLEEP && cke_r |=> state_r == ST_POWER_ON)
      else $error("deep sleep exit missed");
   a_pd_enter: assert property (
      @(posedge i_link_clk) disable iff (link_rst_r)
      state_r == ST_ACTIVE && cke_prev_r && !cke_r && cs_n_r
      |=> state_r == ST_ACTIVE_LP)
      else $error("active power-down entry missed");
   a_autonomous_refresh_state_source: assert property (
      @(posedge i_link_clk) disable iff (link_rst_r)
      (state_r != ST_AUTO_REFRESH) ##1 (state_r == ST_AUTO_REFRESH)
      |-> $past(state_r) == ST_IDLE)
      else $error("self refresh entered from a busy state");
   a_precharge_all: assert property (
      @(posedge i_link_clk) disable iff (link_rst_r)
      state_r inside {ST_IDLE, ST_ACTIVE} && cmd == CMD_PRECHARGE
      && ca_rise_r[ALL_BANK_BIT] && !(burst_r == 8'h01 && ap_pend_r)
      |=> banks_r == BANKS_RST && state_r == ST_IDLE)
      else $error("all-bank precharge left a bank open");
   a_ap_close: assert property (
      @(posedge i_link_clk) disable iff (link_rst_r)
      burst_r == 8'h01 && ap_pend_r && cmd != CMD_ACTIVATE
      |=> !banks_r[$past(ap_bank_r)] && !ap_pend_r)
      else $error("auto precharge did not close the bank");
   a_nop_burst: assert property (
      @(posedge i_link_clk) disable iff (link_rst_r)
      burst_r > 8'h01 && cmd == CMD_NOP
      |=> burst_r == $past(burst_r) - 8'h01)
      else $error("no-op disturbed a running burst");
   a_bank_open: assert property (
      @(posedge i_link_clk) disable iff (link_rst_r)
      state_r inside {ST_IDLE, ST_ACTIVE} && cmd == CMD_ACTIVATE
      |=> banks_r[$past(bank)] && state_r == ST_ACTIVE)
      else $error("activate did not open the addressed bank");
   a_col_zero: assert property (
      @(posedge i_clock) disable iff (i_reset)
      o_cmd_valid |-> o_cmd_col[0] == 1'b0)
      else $error("lowest column bit not zero");

   c_autonomous_refresh_state_entry: cover property (@(posedge i_link_clk)
      disable iff (link_rst_r) state_r == ST_AUTO_REFRESH);
   c_deep_exit: cover property (@(posedge i_link_clk)
      disable iff (link_rst_r)
      state_r == ST_DEEP_SLEEP ##1 state_r == ST_POWER_ON);
   c_ap_burst: cover property (@(posedge i_link_clk)
      disable iff (link_rst_r) burst_r == 8'h01 && ap_pend_r);
   c_pd_exit: cover property (@(posedge i_link_clk)
      disable iff (link_rst_r)
      state_r == ST_IDLE_LP ##1 state_r == ST_IDLE);

endmodule

// file: tb/sdram_ctl_model.sv
// controller model driving chip select, clock enable and the bus
// assumes the bench supplies a free-running link clock
module sdram_ctl_model
   import sdram_cke_pkg::*;
#(
   parameter int EXIT_NOPS = 4
)
(
   input wire logic i_link_clk,
   output logic o_cs_n,
   output logic o_cke,
   output logic [CA_W-1:0] o_cmd_addr_bus
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------------------------
   // idle levels
   // ---------------------------------------------------------------
   // every bit driven to a defined level, never left floating
   initial
   begin
      o_cs_n = 1'b1;
      o_cke = 1'b1;
      o_cmd_addr_bus = 10'h155;
   end
   // ---------------------------------------------------------------
   // one command: rise half, fall half, then a no-op edge
   // ---------------------------------------------------------------
   // callers ask only for listed combinations; eight banks here,
   // so per-bank refresh is allowed
   task automatic send(input logic cke, input logic cs_n,
      input logic [CA_W-1:0] r, input logic [CA_W-1:0] f);
      @(posedge i_link_clk);
      #1;
      o_cke = cke;
      o_cs_n = cs_n;
      o_cmd_addr_bus = r;
      // rise half and chip select are taken at this edge
      @(posedge i_link_clk);
      #1;
      // chip select up at once, or the next edge is a second command
      o_cs_n = 1'b1;
      // fall half taken at the falling edge in between
      o_cmd_addr_bus = f;
      @(posedge i_link_clk);
      #1;
      // don't-care bits still get a defined, changed level
      o_cmd_addr_bus = ~f;
   endtask
   // no-ops only while the clock keeps toggling
   task automatic exit_wait();
      repeat (EXIT_NOPS) @(posedge i_link_clk);
   endtask
endmodule

// file: tb/test_sdram_cke_power_state_decoder.sv
// bench for command capture and clock-enable power states
// assumes the controller model drives chip select, clock enable and the bus
module test_sdram_cke_power_state_decoder
   import sdram_cke_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clock = 1'b0;
   logic i_link_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_final_init_wait_done = 1'b0;
   logic i_cs_n;
   logic i_cke;
   logic [CA_W-1:0] i_cmd_addr_bus;
   logic [3:0] o_power_state;
   logic [NUM_BANKS-1:0] o_banks_open;
   logic o_burst_active;
   logic o_cmd_valid;
   logic [3:0] o_cmd_code;
   logic [BANK_W-1:0] o_cmd_bank;
   logic [COL_W-1:0] o_cmd_col;
   logic o_cmd_auto_precharge_flag;
   logic o_cmd_all_bank_flag;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   typedef struct packed {
      logic [9:0] r;
      logic [9:0] f;
      logic [3:0] code;
      logic [7:0] banks;
      logic [3:0] st;
   } row_t;
   // ---------------------------------------------------------------
   // ordinary commands, issued from idle in this order
   // ---------------------------------------------------------------
   row_t rows [11] = '{
      '{10'h102, 10'h000, CMD_ACTIVATE, 8'h04, ST_ACTIVE},
      '{10'h282, 10'h3fe, CMD_ACTIVATE, 8'h24, ST_ACTIVE},
      '{10'h2f9, 10'h2aa, CMD_WRITE, 8'h24, ST_ACTIVE},
      '{10'h10b, 10'h3ff, CMD_PRECHARGE, 8'h20, ST_ACTIVE},
      '{10'h285, 10'h155, CMD_READ, 8'h00, ST_IDLE},
      '{10'h082, 10'h000, CMD_ACTIVATE, 8'h02, ST_ACTIVE},
      '{10'h382, 10'h001, CMD_ACTIVATE, 8'h82, ST_ACTIVE},
      '{10'h21b, 10'h000, CMD_PRECHARGE, 8'h00, ST_IDLE},
      '{10'h00c, 10'h2aa, CMD_REF_ALL, 8'h00, ST_IDLE},
      '{10'h004, 10'h155, CMD_REF_BANK, 8'h00, ST_IDLE},
      '{10'h008, 10'h0f0, CMD_MRR, 8'h00, ST_IDLE}
   };
   // ---------------------------------------------------------------
   // clocks, reset, instances
   // ---------------------------------------------------------------
   initial
      forever #4 i_clock = ~i_clock;
   // odd offset keeps the two clocks apart in phase
   initial
   begin
      #3.3;
      forever #16 i_link_clk = ~i_link_clk;
   end
   initial
   begin
      repeat (16) @(posedge i_clock);
      #1;
      i_reset = 1'b0;
   end
   // long burst so a stop command is visibly early
   sdram_cke_power_state_decoder #(.BURST_CYCLES(40)) dut (
      .i_clock(i_clock), .i_reset(i_reset), .i_link_clk(i_link_clk),
      .i_cs_n(i_cs_n), .i_cke(i_cke), .i_cmd_addr_bus(i_cmd_addr_bus),
      .i_final_init_wait_done(i_final_init_wait_done),
      .o_power_state(o_power_state), .o_banks_open(o_banks_open),
      .o_burst_active(o_burst_active), .o_cmd_valid(o_cmd_valid),
      .o_cmd_code(o_cmd_code), .o_cmd_bank(o_cmd_bank),
      .o_cmd_col(o_cmd_col),
      .o_cmd_auto_precharge_flag(o_cmd_auto_precharge_flag),
      .o_cmd_all_bank_flag(o_cmd_all_bank_flag));
   sdram_ctl_model ctl (.i_link_clk(i_link_clk), .o_cs_n(i_cs_n),
      .o_cke(i_cke), .o_cmd_addr_bus(i_cmd_addr_bus));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_valid();
      int n;
      n = 0;
      while (o_cmd_valid !== 1'b1 && n < 300)
      begin
         @(posedge i_clock);
         #1;
         n++;
      end
      check(16'(o_cmd_valid), 16'h0001);
   endtask
   // status crosses late, so settle first, then poll with a bound
   task automatic expect_state(input logic [3:0] st, input logic [7:0] bk);
      int n;
      n = 0;
      repeat (40) @(posedge i_clock);
      #1;
      while (!(o_power_state === st && o_banks_open === bk &&
         o_burst_active === 1'b0) && n < 300)
      begin
         @(posedge i_clock);
         #1;
         n++;
      end
      check(16'(o_power_state), 16'(st));
      check(16'(o_banks_open), 16'(bk));
   endtask
   task automatic pd_enter();
      ctl.send(1'b0, 1'b1, 10'h3ff, 10'h3ff);
   endtask
   task automatic pd_exit();
      ctl.send(1'b1, 1'b1, 10'h2aa, 10'h155);
      ctl.exit_wait();
   endtask
   task automatic end_of_test();
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge i_clock)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         miscompares++;
         end_of_test();
      end
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      wait (i_reset === 1'b0);
      repeat (4) @(posedge i_link_clk);
      check(16'(o_power_state), 16'(ST_POWER_ON));
      check(16'(o_banks_open), 16'(BANKS_RST));
      ctl.send(1'b1, 1'b0, 10'h000, 10'h000);
      expect_state(ST_RESETTING, 8'h00);
      pd_enter();
      expect_state(ST_RESET_LP, 8'h00);
      ctl.send(1'b0, 1'b0, 10'h000, 10'h3ff);
      expect_state(ST_RESET_LP, 8'h00);
      pd_exit();
      expect_state(ST_RESETTING, 8'h00);
      pd_enter();
      expect_state(ST_RESET_LP, 8'h00);
      @(posedge i_clock);
      #1;
      i_final_init_wait_done = 1'b1;
      repeat (8) @(posedge i_link_clk);
      pd_exit();
      expect_state(ST_IDLE, 8'h00);
      foreach (rows[i])
      begin
         ctl.send(1'b1, 1'b0, rows[i].r, rows[i].f);
         wait_valid();
         check(16'(o_cmd_code), 16'(rows[i].code));
         check(16'(o_cmd_bank), 16'(rows[i].r[9:7]));
         check(16'(o_cmd_all_bank_flag), 16'(rows[i].r[4]));
         check(16'(o_cmd_auto_precharge_flag), 16'(rows[i].f[0]));
         check(16'(o_cmd_col), 16'({rows[i].f[9:1], rows[i].r[6:5], 1'b0}));
         expect_state(rows[i].st, rows[i].banks);
      end
      pd_enter();
      expect_state(ST_IDLE_LP, 8'h00);
      pd_exit();
      expect_state(ST_IDLE, 8'h00);
      ctl.send(1'b1, 1'b0, 10'h302, 10'h000);
      pd_enter();
      expect_state(ST_ACTIVE_LP, 8'h40);
      ctl.send(1'b0, 1'b0, 10'h004, 10'h000);
      expect_state(ST_ACTIVE_LP, 8'h40);
      pd_exit();
      expect_state(ST_ACTIVE, 8'h40);
      // refused: self refresh entry with a bank open
      ctl.send(1'b0, 1'b0, 10'h004, 10'h000);
      pd_exit();
      expect_state(ST_ACTIVE, 8'h40);
      ctl.send(1'b1, 1'b0, 10'h30b, 10'h000);
      expect_state(ST_IDLE, 8'h00);
      ctl.send(1'b0, 1'b0, 10'h004, 10'h000);
      expect_state(ST_AUTO_REFRESH, 8'h00);
      ctl.send(1'b0, 1'b0, 10'h0aa, 10'h3ff);
      expect_state(ST_AUTO_REFRESH, 8'h00);
      pd_exit();
      expect_state(ST_IDLE, 8'h00);
      ctl.send(1'b0, 1'b0, 10'h003, 10'h000);
      expect_state(ST_DEEP_SLEEP, 8'h00);
      pd_exit();
      expect_state(ST_POWER_ON, 8'h00);
      ctl.send(1'b1, 1'b0, 10'h000, 10'h000);
      expect_state(ST_IDLE, 8'h00);
      // no-ops of both forms while a read burst runs
      ctl.send(1'b1, 1'b0, 10'h182, 10'h000);
      ctl.send(1'b1, 1'b0, 10'h185, 10'h000);
      ctl.send(1'b1, 1'b0, 10'h3ff, 10'h3ff);
      ctl.send(1'b1, 1'b1, 10'h000, 10'h000);
      repeat (8) @(posedge i_clock);
      #1;
      check(16'(o_burst_active), 16'h0001);
      ctl.send(1'b1, 1'b0, 10'h003, 10'h000);
      repeat (40) @(posedge i_clock);
      #1;
      check(16'(o_burst_active), 16'h0000);
      expect_state(ST_ACTIVE, 8'h08);
      ctl.send(1'b1, 1'b0, 10'h18b, 10'h000);
      expect_state(ST_IDLE, 8'h00);
      end_of_test();
   end
endmodule
